// [hw/dmr_consts.svh]
// Purpose: offsets, field positions, identifiers and reset values of the monitor result bank
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   definitions only
`ifndef DMR_CONSTS_SVH
`define DMR_CONSTS_SVH

`define DMR_NUM_SOURCES        7
`define DMR_RESULT_W           12

// register byte addresses
`define DMR_ADDR_OUT1_NEG_HIGH 8'h64
`define DMR_ADDR_OUT1_NEG_LOW  8'h65
`define DMR_ADDR_OUT2_POS_HIGH 8'h66
`define DMR_ADDR_OUT2_POS_LOW  8'h67
`define DMR_ADDR_OUT2_NEG_HIGH 8'h68
`define DMR_ADDR_OUT2_NEG_LOW  8'h69
`define DMR_ADDR_DIE_TEMP_HIGH 8'h6A
`define DMR_ADDR_DIE_TEMP_LOW  8'h6B
`define DMR_ADDR_BIAS_LD_HIGH  8'h6C
`define DMR_ADDR_BIAS_LD_LOW   8'h6D
`define DMR_ADDR_SUPPLY_HIGH   8'h6E
`define DMR_ADDR_SUPPLY_LOW    8'h6F
`define DMR_ADDR_GP_ANA_HIGH   8'h70
`define DMR_ADDR_GP_ANA_LOW    8'h71

// fixed source identifiers in the low register
`define DMR_ID_OUT1_NEG        4'h7
`define DMR_ID_OUT2_POS        4'h8
`define DMR_ID_OUT2_NEG        4'h9
`define DMR_ID_DIE_TEMP        4'hA
`define DMR_ID_BIAS_LD         4'hB
`define DMR_ID_SUPPLY          4'hC
`define DMR_ID_GP_ANA          4'hD

// field positions
`define DMR_RES_HIGH_MSB       11
`define DMR_RES_HIGH_LSB       4
`define DMR_RES_LOW_MSB        3
`define DMR_RES_LOW_LSB        0

// reset and default values
`define DMR_RESULT_RESET       12'h000
`define DMR_UNMAPPED_READ      8'h00

`endif

// [hw/dmr_pkg.sv]
// Purpose: types shared by the monitor result bank
// Assumes: nothing beyond the consts header
// Notes:   numbers live in dmr_consts.svh
package dmr_pkg;

    typedef logic [7:0]  dmr_byte_t;
    typedef logic [7:0]  dmr_addr_t;
    typedef logic [3:0]  dmr_nibble_t;
    typedef logic [11:0] dmr_result_t;

    typedef enum logic [2:0] {
        DMR_SRC_OUT1_NEG = 3'h0,
        DMR_SRC_OUT2_POS = 3'h1,
        DMR_SRC_OUT2_NEG = 3'h2,
        DMR_SRC_DIE_TEMP = 3'h3,
        DMR_SRC_BIAS_LD  = 3'h4,
        DMR_SRC_SUPPLY   = 3'h5,
        DMR_SRC_GP_ANA   = 3'h6
    } dmr_src_t;

endpackage : dmr_pkg

// [hw/dmr_result_regs.sv]
// Purpose: read-only result register pairs of the diagnostic monitor
// Assumes: one clock; register port strobes are single-cycle and synchronous
// Notes:   read data is registered, valid one cycle after the read strobe
`timescale 1ns/1ns
`include "dmr_consts.svh"

module dmr_result_regs #(
    parameter int NUM_SOURCES = `DMR_NUM_SOURCES,
    parameter int RESULT_W    = `DMR_RESULT_W
) (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_srst,
    // conversion results from the monitor sequencer
    input  wire logic                 i_result_valid,
    input  wire dmr_pkg::dmr_src_t    i_result_src,
    input  wire dmr_pkg::dmr_result_t i_result_data,
    // freeze control from the monitor configuration register
    input  wire logic                 i_freeze_monitor_results,
    // register port
    input  wire dmr_pkg::dmr_addr_t   i_reg_addr,
    input  wire logic                 i_reg_rd,
    input  wire logic                 i_reg_wr,
    input  wire dmr_pkg::dmr_byte_t   i_reg_wdata,
    output dmr_pkg::dmr_byte_t        o_reg_rdata,
    output logic                      o_reg_rvalid,
    output logic                      o_reg_hit,
    output logic                      o_reg_wr_ignored
);
    import dmr_pkg::*;

    // the address and identifier tables are fixed, so the counts cannot move
    if (NUM_SOURCES != `DMR_NUM_SOURCES) begin : g_chk_src
        $error("NUM_SOURCES must match the fixed register table");
    end
    if (RESULT_W != `DMR_RESULT_W) begin : g_chk_w
        $error("RESULT_W must be 12");
    end

    localparam dmr_addr_t HIGH_ADDR [`DMR_NUM_SOURCES] = '{
        `DMR_ADDR_OUT1_NEG_HIGH,
        `DMR_ADDR_OUT2_POS_HIGH,
        `DMR_ADDR_OUT2_NEG_HIGH,
        `DMR_ADDR_DIE_TEMP_HIGH,
        `DMR_ADDR_BIAS_LD_HIGH,
        `DMR_ADDR_SUPPLY_HIGH,
        `DMR_ADDR_GP_ANA_HIGH
    };

    localparam dmr_addr_t LOW_ADDR [`DMR_NUM_SOURCES] = '{
        `DMR_ADDR_OUT1_NEG_LOW,
        `DMR_ADDR_OUT2_POS_LOW,
        `DMR_ADDR_OUT2_NEG_LOW,
        `DMR_ADDR_DIE_TEMP_LOW,
        `DMR_ADDR_BIAS_LD_LOW,
        `DMR_ADDR_SUPPLY_LOW,
        `DMR_ADDR_GP_ANA_LOW
    };

    localparam dmr_nibble_t SRC_ID [`DMR_NUM_SOURCES] = '{
        `DMR_ID_OUT1_NEG,
        `DMR_ID_OUT2_POS,
        `DMR_ID_OUT2_NEG,
        `DMR_ID_DIE_TEMP,
        `DMR_ID_BIAS_LD,
        `DMR_ID_SUPPLY,
        `DMR_ID_GP_ANA
    };

    localparam int RES_ALL_W = `DMR_NUM_SOURCES * `DMR_RESULT_W;

    dmr_result_t              res       [`DMR_NUM_SOURCES];
    dmr_byte_t                high_byte [`DMR_NUM_SOURCES];
    dmr_byte_t                low_byte  [`DMR_NUM_SOURCES];
    logic [NUM_SOURCES-1:0]   load;
    logic [NUM_SOURCES-1:0]   hit_high;
    logic [NUM_SOURCES-1:0]   hit_low;
    logic [RES_ALL_W-1:0]     res_all;

    dmr_byte_t                rd_data_d;
    logic                     rd_hit_d;
    dmr_byte_t                rdata_q;
    logic                     rvalid_q;
    logic                     hit_q;
    logic                     wr_ign_q;

    for (genvar k = 0; k < `DMR_NUM_SOURCES; k++) begin : g_src
        assign load[k]     = i_result_valid && (i_result_src == dmr_src_t'(k));
        assign hit_high[k] = (i_reg_addr == HIGH_ADDR[k]);
        assign hit_low[k]  = (i_reg_addr == LOW_ADDR[k]);

        dmr_result_slot u_slot (
            .i_mclk   (i_mclk),
            .i_srst   (i_srst),
            .i_load   (load[k]),
            .i_freeze (i_freeze_monitor_results),
            .i_data   (i_result_data),
            .o_result (res[k])
        );

        assign high_byte[k] = res[k][`DMR_RES_HIGH_MSB:`DMR_RES_HIGH_LSB];
        assign low_byte[k]  = {res[k][`DMR_RES_LOW_MSB:`DMR_RES_LOW_LSB], SRC_ID[k]};
        assign res_all[k*`DMR_RESULT_W +: `DMR_RESULT_W] = res[k];
    end

    // read mux; unmapped addresses answer zero with hit low
    always_comb begin
        rd_data_d = `DMR_UNMAPPED_READ;
        rd_hit_d  = 1'b0;
        for (int k = 0; k < `DMR_NUM_SOURCES; k++) begin
            if (hit_high[k]) begin
                rd_data_d = high_byte[k];
                rd_hit_d  = 1'b1;
            end
            if (hit_low[k]) begin
                rd_data_d = low_byte[k];
                rd_hit_d  = 1'b1;
            end
        end
    end

    // data held between reads so software sees a steady byte
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_q <= `DMR_UNMAPPED_READ;
            hit_q   <= 1'b0;
        end else if (i_reg_rd) begin
            rdata_q <= rd_data_d;
            hit_q   <= rd_hit_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_reg_rd;
        end
    end

    // write data is never stored; a write to a mapped address is flagged only
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            wr_ign_q <= 1'b0;
        end else begin
            wr_ign_q <= i_reg_wr && (|{hit_high, hit_low});
        end
    end

    assign o_reg_rdata      = rdata_q;
    assign o_reg_rvalid     = rvalid_q;
    assign o_reg_hit        = hit_q;
    assign o_reg_wr_ignored = wr_ign_q;

    // per-source readback and update checks
    for (genvar k = 0; k < `DMR_NUM_SOURCES; k++) begin : g_chk
        property p_high_read;
            @(posedge i_mclk) disable iff (i_srst)
            (i_reg_rd && hit_high[k]) |=>
                (o_reg_rdata == $past(res[k][`DMR_RES_HIGH_MSB:`DMR_RES_HIGH_LSB])) && o_reg_hit;
        endproperty
        a_high_read : assert property (p_high_read)
            else $error("high register readback wrong");

        property p_low_read;
            @(posedge i_mclk) disable iff (i_srst)
            (i_reg_rd && hit_low[k]) |=>
                (o_reg_rdata[7:4] == $past(res[k][`DMR_RES_LOW_MSB:`DMR_RES_LOW_LSB])) &&
                o_reg_hit;
        endproperty
        a_low_read : assert property (p_low_read)
            else $error("low nibble readback wrong");

        property p_live_update;
            @(posedge i_mclk) disable iff (i_srst)
            (load[k] && !i_freeze_monitor_results) |=> (res[k] == $past(i_result_data));
        endproperty
        a_live_update : assert property (p_live_update)
            else $error("result not updated while not frozen");

        // no load, no freeze now or last cycle, so nothing is parked: value must hold
        property p_no_stray;
            @(posedge i_mclk) disable iff (i_srst)
            !(i_result_valid && i_result_src == dmr_src_t'(k)) &&
                !i_freeze_monitor_results && !$past(i_freeze_monitor_results) |=>
                $stable(res[k]);
        endproperty
        a_no_stray : assert property (p_no_stray)
            else $error("result moved without an update");

        sequence s_park;
            i_result_valid && (i_result_src == dmr_src_t'(k)) && i_freeze_monitor_results;
        endsequence

        property p_park_release;
            @(posedge i_mclk) disable iff (i_srst)
            s_park ##1 (!i_freeze_monitor_results && !i_result_valid) |=>
                (res[k] == $past(i_result_data, 2));
        endproperty
        a_park_release : assert property (p_park_release)
            else $error("parked result not applied on release");
    end

    property p_id_out1_neg;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_OUT1_NEG_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_OUT1_NEG);
    endproperty
    a_id_out1_neg : assert property (p_id_out1_neg)
        else $error("output 1 negative identifier wrong");

    property p_id_out2_pos;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_OUT2_POS_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_OUT2_POS);
    endproperty
    a_id_out2_pos : assert property (p_id_out2_pos)
        else $error("output 2 positive identifier wrong");

    property p_id_out2_neg;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_OUT2_NEG_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_OUT2_NEG);
    endproperty
    a_id_out2_neg : assert property (p_id_out2_neg)
        else $error("output 2 negative identifier wrong");

    property p_id_die_temp;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_DIE_TEMP_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_DIE_TEMP);
    endproperty
    a_id_die_temp : assert property (p_id_die_temp)
        else $error("die temperature identifier wrong");

    property p_id_bias_ld;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_BIAS_LD_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_BIAS_LD);
    endproperty
    a_id_bias_ld : assert property (p_id_bias_ld)
        else $error("bias load identifier wrong");

    property p_id_supply;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_SUPPLY_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_SUPPLY);
    endproperty
    a_id_supply : assert property (p_id_supply)
        else $error("analog supply identifier wrong");

    property p_id_gp_ana;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `DMR_ADDR_GP_ANA_LOW) |=>
            (o_reg_rdata[3:0] == `DMR_ID_GP_ANA) && o_reg_hit;
    endproperty
    a_id_gp_ana : assert property (p_id_gp_ana)
        else $error("general purpose input identifier wrong");

    sequence s_frozen_update;
        i_freeze_monitor_results && i_result_valid;
    endsequence

    sequence s_freeze_run;
        i_freeze_monitor_results [*3];
    endsequence

    property p_freeze_blocks;
        @(posedge i_mclk) disable iff (i_srst)
        s_frozen_update |=> $stable(res_all);
    endproperty
    a_freeze_blocks : assert property (p_freeze_blocks)
        else $error("result changed while frozen");

    property p_freeze_run;
        @(posedge i_mclk) disable iff (i_srst)
        s_freeze_run |=> (res_all == $past(res_all, 2));
    endproperty
    a_freeze_run : assert property (p_freeze_run)
        else $error("result drifted during freeze");

    property p_write_no_effect;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_wr && !i_result_valid && !i_freeze_monitor_results &&
            !$past(i_freeze_monitor_results)) |=> $stable(res_all);
    endproperty
    a_write_no_effect : assert property (p_write_no_effect)
        else $error("write changed a result");

    property p_write_flag;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_wr && (i_reg_addr inside {[`DMR_ADDR_OUT1_NEG_HIGH:`DMR_ADDR_GP_ANA_LOW]}))
            |=> o_reg_wr_ignored;
    endproperty
    a_write_flag : assert property (p_write_flag)
        else $error("ignored write not flagged");

    property p_reset_clear;
        @(posedge i_mclk)
        i_srst |=> (res_all == '0) && (o_reg_rdata == 8'h00) && !o_reg_rvalid;
    endproperty
    a_reset_clear : assert property (p_reset_clear)
        else $error("reset did not clear results");

    property p_unmapped;
        @(posedge i_mclk) disable iff (i_srst)
        (i_reg_rd && !(i_reg_addr inside {[`DMR_ADDR_OUT1_NEG_HIGH:`DMR_ADDR_GP_ANA_LOW]})) |=>
            (o_reg_rdata == 8'h00) && !o_reg_hit && o_reg_rvalid;
    endproperty
    a_unmapped : assert property (p_unmapped)
        else $error("unmapped read answered");

    property p_rvalid_pulse;
        @(posedge i_mclk) disable iff (i_srst)
        !i_reg_rd |=> !o_reg_rvalid;
    endproperty
    a_rvalid_pulse : assert property (p_rvalid_pulse)
        else $error("read valid without a read");

    // software relies on the last read byte staying put between reads
    property p_read_hold;
        @(posedge i_mclk) disable iff (i_srst)
        !i_reg_rd |=> $stable(o_reg_rdata) && $stable(o_reg_hit);
    endproperty
    a_read_hold : assert property (p_read_hold)
        else $error("read data moved between reads");

    property p_wr_flag_only;
        @(posedge i_mclk) disable iff (i_srst)
        !(i_reg_wr && (i_reg_addr inside {[`DMR_ADDR_OUT1_NEG_HIGH:`DMR_ADDR_GP_ANA_LOW]}))
            |=> !o_reg_wr_ignored;
    endproperty
    a_wr_flag_only : assert property (p_wr_flag_only)
        else $error("write flag raised without a mapped write");

endmodule : dmr_result_regs

// [hw/dmr_result_slot.sv]
// Purpose: holds one source's 12-bit result, with freeze and deferred update
// Assumes: load is a one-cycle pulse per finished conversion
// Notes:   a result arriving while frozen is parked and applied on release, unless a fresh result loads in the release cycle
`timescale 1ns/1ns
`include "dmr_consts.svh"

module dmr_result_slot (
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_srst,
    // update side
    input  wire logic                 i_load,
    input  wire logic                 i_freeze,
    input  wire dmr_pkg::dmr_result_t i_data,
    // held value
    output dmr_pkg::dmr_result_t      o_result
);
    import dmr_pkg::*;

    dmr_result_t result_q;
    dmr_result_t pend_q;
    logic        pend_vld_q;

    // only the newest parked result survives; older ones are stale anyway
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            pend_q     <= `DMR_RESULT_RESET;
            pend_vld_q <= 1'b0;
        end else if (i_load && i_freeze) begin
            pend_q     <= i_data;
            pend_vld_q <= 1'b1;
        end else if (!i_freeze) begin
            pend_vld_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            result_q <= `DMR_RESULT_RESET;
        end else if (!i_freeze) begin
            if (i_load) begin
                result_q <= i_data;
            end else if (pend_vld_q) begin
                result_q <= pend_q;
            end
        end
    end

    assign o_result = result_q;

endmodule : dmr_result_slot

// [verif/tb_diag_monitor_result_regs.sv]
// Purpose: self-checking bench for the monitor result register bank
// Assumes: inputs change on the falling edge; read data comes one cycle after the strobe
// Notes:   expected values come from the bench model and the consts header, never from the design outputs
`timescale 1ns/1ns
`include "dmr_consts.svh"

module tb_diag_monitor_result_regs;
    import dmr_pkg::*;

    logic        i_mclk;
    logic        i_srst;
    logic        i_result_valid;
    dmr_src_t    i_result_src;
    dmr_result_t i_result_data;
    logic        i_freeze_monitor_results;
    dmr_addr_t   i_reg_addr;
    logic        i_reg_rd;
    logic        i_reg_wr;
    dmr_byte_t   i_reg_wdata;
    dmr_byte_t   o_reg_rdata;
    logic        o_reg_rvalid;
    logic        o_reg_hit;
    logic        o_reg_wr_ignored;
    int          mismatches;
    int          checks;
    int          cycles;
    dmr_result_t model [0:6];

    dmr_result_regs DUT (
        .i_mclk                   (i_mclk),
        .i_srst                   (i_srst),
        .i_result_valid           (i_result_valid),
        .i_result_src             (i_result_src),
        .i_result_data            (i_result_data),
        .i_freeze_monitor_results (i_freeze_monitor_results),
        .i_reg_addr               (i_reg_addr),
        .i_reg_rd                 (i_reg_rd),
        .i_reg_wr                 (i_reg_wr),
        .i_reg_wdata              (i_reg_wdata),
        .o_reg_rdata              (o_reg_rdata),
        .o_reg_rvalid             (o_reg_rvalid),
        .o_reg_hit                (o_reg_hit),
        .o_reg_wr_ignored         (o_reg_wr_ignored)
    );

    always #10 i_mclk = ~i_mclk;

    // whole sequence needs under two hundred cycles; ceiling leaves ample margin
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic cmp_byte(input string name, input dmr_byte_t exp, input dmr_byte_t got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic reg_read(input dmr_addr_t addr, output dmr_byte_t data, output logic hit);
        @(negedge i_mclk);
        cmp_bit("read valid idle", 1'b0, o_reg_rvalid);
        i_reg_addr = addr;
        i_reg_rd   = 1'b1;
        @(negedge i_mclk);
        i_reg_rd = 1'b0;
        cmp_bit("read valid", 1'b1, o_reg_rvalid);
        data = o_reg_rdata;
        hit  = o_reg_hit;
    endtask : reg_read

    task automatic reg_write(input dmr_addr_t addr, input logic exp_flag);
        @(negedge i_mclk);
        cmp_bit("write flag idle", 1'b0, o_reg_wr_ignored);
        i_reg_addr  = addr;
        i_reg_wdata = 8'hFF;
        i_reg_wr    = 1'b1;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
        cmp_bit("write ignored flag", exp_flag, o_reg_wr_ignored);
    endtask : reg_write

    // reads both halves of one source and compares against the model
    task automatic check_pair(input int s);
        dmr_byte_t d;
        logic      h;
        dmr_addr_t a;
        a = `DMR_ADDR_OUT1_NEG_HIGH + 8'(2 * s);
        reg_read(a, d, h);
        cmp_byte("result high", model[s][11:4], d);
        cmp_bit("hit high", 1'b1, h);
        reg_read(a + 8'h01, d, h);
        cmp_byte("result low", {model[s][3:0], 4'(`DMR_ID_OUT1_NEG + s)}, d);
        cmp_bit("hit low", 1'b1, h);
    endtask : check_pair

    task automatic check_all;
        for (int s = 0; s < 7; s++) begin
            check_pair(s);
        end
    endtask : check_all

    task automatic load(input int s, input dmr_result_t data);
        @(negedge i_mclk);
        i_result_valid = 1'b1;
        i_result_src   = dmr_src_t'(3'(s));
        i_result_data  = data;
        @(negedge i_mclk);
        i_result_valid = 1'b0;
    endtask : load

    initial begin
        dmr_byte_t d;
        logic      h;
        i_mclk = 1'b0;
        i_srst = 1'b1;
        i_result_valid = 1'b0;
        i_result_src = DMR_SRC_OUT1_NEG;
        i_result_data = 12'h000;
        i_freeze_monitor_results = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_rd = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_wdata = 8'h00;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        repeat (2) @(negedge i_mclk);
        i_srst = 1'b0;
        for (int s = 0; s < 7; s++) model[s] = 12'h000;
        check_all();
        // back-to-back updates, one per source plus one to unused source code 7, values from FFF down to 003
        @(negedge i_mclk);
        for (int s = 0; s < 8; s++) begin
            i_result_valid = 1'b1;
            i_result_src   = dmr_src_t'(3'(s));
            i_result_data  = (s == 7) ? 12'h123 : 12'(12'hFFF - 12'h2AA * s);
            if (s < 7) model[s] = i_result_data;
            @(negedge i_mclk);
        end
        i_result_valid = 1'b0;
        check_all();
        // writes change nothing; only mapped addresses raise the flag
        for (int a = 8'h64; a <= 8'h71; a++) reg_write(8'(a), 1'b1);
        reg_write(8'h72, 1'b0);
        reg_write(8'h63, 1'b0);
        check_all();
        reg_read(8'h72, d, h);
        cmp_byte("unmapped data", `DMR_UNMAPPED_READ, d);
        cmp_bit("unmapped hit", 1'b0, h);
        // frozen update must not show until release
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b1;
        load(3, 12'h5C3);
        check_pair(3);
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b0;
        @(negedge i_mclk);
        model[3] = 12'h5C3;
        check_pair(3);
        // two parked updates: the newer shows on release
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b1;
        load(4, 12'h9E1);
        load(4, 12'h1F6);
        i_freeze_monitor_results = 1'b0;
        model[4] = 12'h1F6;
        check_pair(4);
        // a fresh update in the release cycle beats the parked one
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b1;
        i_result_valid = 1'b1;
        i_result_src = DMR_SRC_BIAS_LD;
        i_result_data = 12'h2D4;
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b0;
        i_result_data = 12'hE3B;
        @(negedge i_mclk);
        i_result_valid = 1'b0;
        model[4] = 12'hE3B;
        check_pair(4);
        // second reset in mid-run clears every result and a parked update
        @(negedge i_mclk);
        i_freeze_monitor_results = 1'b1;
        load(5, 12'hABC);
        i_srst = 1'b1;
        @(negedge i_mclk);
        i_srst = 1'b0;
        i_freeze_monitor_results = 1'b0;
        for (int s = 0; s < 7; s++) model[s] = 12'h000;
        check_all();
        end_of_test();
    end

endmodule : tb_diag_monitor_result_regs
